// file: fuse_pkg.sv
// package: configuration word field layouts, codes, ratio constants and loader states
package fuse_pkg;
   // oscillator configuration word fields
   localparam int OSC_PIN_FUNC_BIT = 5;
   localparam int REMAP_ONCE_BIT = 6;
   localparam int CLK_POLICY_LO = 7;
   localparam int PLL_WAIT_BIT = 9;
   // watchdog configuration word fields
   localparam int WDT_POST_LO = 0;
   localparam int WDT_PRE_BIT = 4;
   localparam int WDT_MODE_LO = 5;
   localparam int WDT_WATCHDOG_WINDOW_DISABLE_BIT = 7;
   localparam int WDT_WIN_LO = 8;
   // power and debug word fields
   localparam int BOR_EN_BIT = 3;
   localparam int DBG_CH_LO = 0;
   // word indices into configuration memory
   localparam logic [2:0] IDX_OSC = 3'h0;
   localparam logic [2:0] IDX_WDT = 3'h1;
   localparam logic [2:0] IDX_POR = 3'h2;
   localparam logic [2:0] IDX_DBG = 3'h3;
   localparam logic [2:0] IDX_DMT_IVL = 3'h4;
   localparam logic [2:0] IDX_DMT_IVH = 3'h5;
   localparam logic [2:0] IDX_DMT_CNTL = 3'h6;
   localparam logic [2:0] IDX_LAST = 3'h6;
   localparam int WORD_COUNT = 7;
   // erased flash reads as all ones
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   // clock switch policy codes
   localparam logic [1:0] CKSW_BOTH_ON = 2'h0;
   localparam logic [1:0] CKSW_NO_MON = 2'h1;
   // watchdog enable mode codes
   localparam logic [1:0] WDT_OFF = 2'h0;
   localparam logic [1:0] WDT_ACTIVE = 2'h1;
   localparam logic [1:0] WDT_SOFT = 2'h2;
   localparam logic [1:0] WDT_HARD = 2'h3;
   // prescale ratios
   localparam logic [7:0] PRE_RATIO_HI = 8'h80;
   localparam logic [7:0] PRE_RATIO_LO = 8'h20;
   // window sizes in eighths of the period
   localparam logic [2:0] WIN_75 = 3'h6;
   localparam logic [2:0] WIN_50 = 3'h4;
   localparam logic [2:0] WIN_375 = 3'h3;
   localparam logic [2:0] WIN_25 = 3'h2;
   // debug pin pair one-hot
   localparam logic [2:0] PAIR_1 = 3'h1;
   localparam logic [2:0] PAIR_2 = 3'h2;
   localparam logic [2:0] PAIR_3 = 3'h4;
   localparam logic [2:0] PAIR_NONE = 3'h0;
   localparam logic [1:0] DBG_CODE_P1 = 2'h3;
   localparam logic [1:0] DBG_CODE_P2 = 2'h2;
   localparam logic [1:0] DBG_CODE_P3 = 2'h1;
   // 32-bit halves
   localparam int HALF_W = 16;
   // one postscale step doubles the ratio
   localparam logic [15:0] POST_UNIT = 16'h0001;
   // loader states
   typedef enum logic [1:0] {S_LOAD, S_WAIT, S_DONE} load_state_t;
endpackage

// file: postscale_decode.sv
// module: watchdog postscale code to division ratio
module postscale_decode (
   // code in
   input wire logic [3:0] code,
   // ratio out, code 15 gives 32768
   output logic [15:0] ratio
);
   // each code is double the code below, so 1111 -> 32768, 1110 -> 16384
   always_comb begin
      ratio = fuse_pkg::POST_UNIT << code;
   end
endmodule

// file: config_fuse_decoder.sv
// module: reset-time loader and decoder of configuration words
module config_fuse_decoder #(
   parameter int WORD_W = 16
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // configuration memory read port (one cycle latency)
   output logic [2:0] CFG_ADDR,
   input wire logic [WORD_W-1:0] CFG_DATA,
   // live status from clock, sleep and software
   input wire logic XTAL_OR_HS_MODE,
   input wire logic SLEEP_ACTIVE,
   input wire logic SOFT_WATCHDOG_ENABLE,
   input wire logic PLL_LOCKED,
   input wire logic PLL_SWITCH_REQ,
   input wire logic REMAP_REQ,
   // load status
   output logic CFG_LOADED,
   // oscillator controls
   output logic SECOND_OSCILLATOR_PIN_CLOCK_OUT,
   output logic REMAP_ALLOWED,
   output logic CLOCK_SWITCH_EN,
   output logic FAILSAFE_MON_EN,
   output logic PLL_SWITCH_GO,
   // watchdog controls
   output logic [15:0] WDT_POST_RATIO,
   output logic [7:0] WDT_PRE_RATIO,
   output logic WDT_RUN,
   output logic WDT_SOFT_BIT_LIVE,
   output logic WDT_WINDOW_MODE,
   output logic [2:0] WDT_WINDOW_EIGHTHS,
   // reset and debug controls
   output logic BOR_EN,
   output logic [2:0] DEBUG_PAIR,
   output logic DEBUG_RESERVED,
   // deadman values
   output logic [31:0] DMT_INTERVAL,
   output logic [31:0] DMT_COUNT
);
   // raw word store, flip-flops indexed by word number
   localparam int WORD_COUNT_P = fuse_pkg::WORD_COUNT;
   logic [WORD_W-1:0] words [WORD_COUNT_P];
   logic [WORD_W-1:0] next_words [WORD_COUNT_P];
   fuse_pkg::load_state_t state, next_state;
   logic [2:0] addr, next_addr;
   logic [2:0] cap, next_cap; // index of word now on CFG_DATA
   logic remap_used, next_remap_used; // one-way remap latch
   logic [15:0] post_ratio;

   // decoded views of the held words
   logic [15:0] w_osc, w_wdt, w_por, w_dbg;
   assign w_osc = words[fuse_pkg::IDX_OSC][15:0];
   assign w_wdt = words[fuse_pkg::IDX_WDT][15:0];
   assign w_por = words[fuse_pkg::IDX_POR][15:0];
   assign w_dbg = words[fuse_pkg::IDX_DBG][15:0];

   // two-bit field pick, used for every two-bit coded field (the four-bit postscale code goes to postscale_decode)
   function automatic logic [1:0] field2(input logic [15:0] w,
                                         input int lo);
      field2 = w[lo +: 2];
   endfunction

   // loader: walk all words once after reset, then freeze
   always_comb begin
      next_state = state;
      next_addr = addr;
      next_cap = cap;
      next_words = words;
      next_remap_used = remap_used;
      unique case (state)
         fuse_pkg::S_LOAD: begin
            next_cap = addr;
            next_state = fuse_pkg::S_WAIT;
            if (addr != fuse_pkg::IDX_LAST) begin
               next_addr = 3'(addr + 3'h1);
            end
         end
         fuse_pkg::S_WAIT: begin
            // data for cap arrives now; store it
            next_words[cap] = CFG_DATA;
            if (cap == fuse_pkg::IDX_LAST) begin
               next_state = fuse_pkg::S_DONE;
            end else begin
               next_cap = addr;
               if (addr != fuse_pkg::IDX_LAST) begin
                  next_addr = 3'(addr + 3'h1);
               end
            end
         end
         fuse_pkg::S_DONE: begin
            // nothing changes words until the next reset
            if (REMAP_REQ && w_osc[fuse_pkg::REMAP_ONCE_BIT]) begin
               next_remap_used = 1'b1;
            end
         end
      endcase
   end

   // loader registers; words reset to erased value
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= fuse_pkg::S_LOAD;
         addr <= fuse_pkg::IDX_OSC;
         cap <= fuse_pkg::IDX_OSC;
         remap_used <= 1'b0;
         for (int i = 0; i < WORD_COUNT_P; i++) begin
            words[i] <= WORD_W'(fuse_pkg::ERASED_WORD);
         end
      end else begin
         state <= next_state;
         addr <= next_addr;
         cap <= next_cap;
         remap_used <= next_remap_used;
         words <= next_words;
      end
   end

   postscale_decode postscale_decode_i (
      .code(w_wdt[fuse_pkg::WDT_POST_LO +: 4]),
      .ratio(post_ratio)
   );

   // output decode, next values
   logic next_loaded, next_second_oscillator_pin, next_remap, next_cksw, next_fscm;
   logic next_pllgo, next_run, next_soft, next_winmode, next_bor;
   logic next_dres;
   logic [7:0] next_pre;
   logic [2:0] next_win, next_pair;
   logic [31:0] next_interval, next_count; // deadman values
   logic loaded;
   assign loaded = (state == fuse_pkg::S_DONE);

   // decode runs every cycle; the held words keep results that use no live input constant
   always_comb begin
      next_loaded = loaded;
      // clock output only outside crystal and high-speed modes
      next_second_oscillator_pin = w_osc[fuse_pkg::OSC_PIN_FUNC_BIT] &&
                  !XTAL_OR_HS_MODE;
      // lock bit clear: unlimited remaps; set: first one only
      next_remap = loaded && !remap_used;
      if (!w_osc[fuse_pkg::REMAP_ONCE_BIT]) begin
         next_remap = loaded;
      end
      // clock switch policy
      next_cksw = 1'b0;
      next_fscm = 1'b0;
      unique case (field2(w_osc, fuse_pkg::CLK_POLICY_LO))
         fuse_pkg::CKSW_BOTH_ON: begin
            next_cksw = 1'b1;
            next_fscm = 1'b1;
         end
         fuse_pkg::CKSW_NO_MON: begin
            next_cksw = 1'b1;
         end
         default: begin
            next_cksw = 1'b0;
         end
      endcase
      // pll switch waits for lock only when asked; a policy that
      // forbids switching also blocks the pll switch
      next_pllgo = PLL_SWITCH_REQ && next_cksw && loaded &&
                   (PLL_LOCKED ||
                    !w_osc[fuse_pkg::PLL_WAIT_BIT]);
      // prescale bit picks the larger ratio when set
      if (w_wdt[fuse_pkg::WDT_PRE_BIT]) begin
         next_pre = fuse_pkg::PRE_RATIO_HI;
      end else begin
         next_pre = fuse_pkg::PRE_RATIO_LO;
      end
      // watchdog enable mode; run stays low until all words are in
      next_run = 1'b0;
      next_soft = 1'b0;
      unique case (field2(w_wdt, fuse_pkg::WDT_MODE_LO))
         fuse_pkg::WDT_HARD: next_run = 1'b1;
         fuse_pkg::WDT_SOFT: begin
            next_run = SOFT_WATCHDOG_ENABLE;
            next_soft = 1'b1;
         end
         fuse_pkg::WDT_ACTIVE: next_run = !SLEEP_ACTIVE;
         fuse_pkg::WDT_OFF: next_run = 1'b0;
      endcase
      next_run = next_run && loaded;
      next_winmode = !w_wdt[fuse_pkg::WDT_WATCHDOG_WINDOW_DISABLE_BIT];
      next_win = fuse_pkg::WIN_75;
      unique case (field2(w_wdt, fuse_pkg::WDT_WIN_LO))
         2'h3: next_win = fuse_pkg::WIN_25;
         2'h2: next_win = fuse_pkg::WIN_375;
         2'h1: next_win = fuse_pkg::WIN_50;
         2'h0: next_win = fuse_pkg::WIN_75;
      endcase
      next_bor = w_por[fuse_pkg::BOR_EN_BIT];
      next_dres = 1'b0;
      next_pair = fuse_pkg::PAIR_NONE;
      unique case (field2(w_dbg, fuse_pkg::DBG_CH_LO))
         fuse_pkg::DBG_CODE_P1: next_pair = fuse_pkg::PAIR_1;
         fuse_pkg::DBG_CODE_P2: next_pair = fuse_pkg::PAIR_2;
         fuse_pkg::DBG_CODE_P3: next_pair = fuse_pkg::PAIR_3;
         default: begin
            // reserved code: route nowhere and flag it
            next_pair = fuse_pkg::PAIR_NONE;
            next_dres = 1'b1;
         end
      endcase
      // interval: high word over low word
      next_interval = {words[fuse_pkg::IDX_DMT_IVH][15:0],
                       words[fuse_pkg::IDX_DMT_IVL][15:0]};
      // count: only the low half is configured; high half zero
      next_count = {16'h0,
                    words[fuse_pkg::IDX_DMT_CNTL][15:0]};
   end

   // output registers; safe defaults in reset, then decoded from the words as they load
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CFG_ADDR <= fuse_pkg::IDX_OSC;
         CFG_LOADED <= 1'b0;
         SECOND_OSCILLATOR_PIN_CLOCK_OUT <= 1'b0;
         REMAP_ALLOWED <= 1'b0;
         CLOCK_SWITCH_EN <= 1'b0;
         FAILSAFE_MON_EN <= 1'b0;
         PLL_SWITCH_GO <= 1'b0;
         WDT_POST_RATIO <= fuse_pkg::POST_UNIT;
         WDT_PRE_RATIO <= fuse_pkg::PRE_RATIO_LO;
         WDT_RUN <= 1'b0;
         WDT_SOFT_BIT_LIVE <= 1'b0;
         WDT_WINDOW_MODE <= 1'b0;
         WDT_WINDOW_EIGHTHS <= fuse_pkg::WIN_75;
         BOR_EN <= 1'b0;
         DEBUG_PAIR <= fuse_pkg::PAIR_NONE;
         DEBUG_RESERVED <= 1'b0;
         DMT_INTERVAL <= 32'h0;
         DMT_COUNT <= 32'h0;
      end else begin
         CFG_ADDR <= next_addr;
         CFG_LOADED <= next_loaded;
         SECOND_OSCILLATOR_PIN_CLOCK_OUT <= next_second_oscillator_pin;
         REMAP_ALLOWED <= next_remap;
         CLOCK_SWITCH_EN <= next_cksw;
         FAILSAFE_MON_EN <= next_fscm;
         PLL_SWITCH_GO <= next_pllgo;
         WDT_POST_RATIO <= post_ratio;
         WDT_PRE_RATIO <= next_pre;
         WDT_RUN <= next_run;
         WDT_SOFT_BIT_LIVE <= next_soft;
         WDT_WINDOW_MODE <= next_winmode;
         WDT_WINDOW_EIGHTHS <= next_win;
         BOR_EN <= next_bor;
         DEBUG_PAIR <= next_pair;
         DEBUG_RESERVED <= next_dres;
         DMT_INTERVAL <= next_interval;
         DMT_COUNT <= next_count;
      end
   end

   // once loaded the words never change until reset
   words_frozen_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      $past(loaded) |-> $stable(DMT_INTERVAL))
      else $error("deadman interval changed after load");
   policy_hi_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      w_osc[fuse_pkg::CLK_POLICY_LO + 1] ##1 $stable(w_osc)
      |-> !CLOCK_SWITCH_EN && !FAILSAFE_MON_EN)
      else $error("policy 1x left switching on");
   monitor_on_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      field2(w_osc, fuse_pkg::CLK_POLICY_LO) == fuse_pkg::CKSW_BOTH_ON
      ##1 $stable(w_osc) |-> CLOCK_SWITCH_EN && FAILSAFE_MON_EN)
      else $error("policy 00 left monitor off");
   pll_wait_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      PLL_SWITCH_GO |-> $past(PLL_LOCKED) ||
      !$past(w_osc[fuse_pkg::PLL_WAIT_BIT]))
      else $error("pll switch without lock");
   wdt_hard_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      loaded && field2(w_wdt, fuse_pkg::WDT_MODE_LO) == fuse_pkg::WDT_HARD
      |=> WDT_RUN)
      else $error("hard watchdog not running");
   wdt_soft_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      loaded && field2(w_wdt, fuse_pkg::WDT_MODE_LO) == fuse_pkg::WDT_SOFT
      |=> WDT_RUN == $past(SOFT_WATCHDOG_ENABLE))
      else $error("soft watchdog not following bit");
   wdt_sleep_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      field2(w_wdt, fuse_pkg::WDT_MODE_LO) == fuse_pkg::WDT_ACTIVE
      && SLEEP_ACTIVE |=> !WDT_RUN)
      else $error("watchdog ran in sleep");
   post_ratio_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      w_wdt[3:0] == 4'hf |=> WDT_POST_RATIO == 16'h8000)
      else $error("postscale 1111 not 32768");
   pre_ratio_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      w_wdt[fuse_pkg::WDT_PRE_BIT] |=> WDT_PRE_RATIO == 8'h80)
      else $error("prescale set not 128");
   remap_once_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      remap_used |-> ##1 !REMAP_ALLOWED)
      else $error("second remap allowed");
   debug_pair_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      field2(w_dbg, fuse_pkg::DBG_CH_LO) == fuse_pkg::DBG_CODE_P1
      |=> DEBUG_PAIR == fuse_pkg::PAIR_1)
      else $error("debug code 11 not pair 1");
   // crystal or high-speed mode always frees the pin from clock out
   osc_pin_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      XTAL_OR_HS_MODE |=> !SECOND_OSCILLATOR_PIN_CLOCK_OUT)
      else $error("clock out driven in crystal mode");
   bor_enable_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_LOADED |-> BOR_EN == w_por[fuse_pkg::BOR_EN_BIT])
      else $error("brown-out enable not the loaded bit");
endmodule

// file: tb_config_fuse_decoder.sv
// testbench: random and corner configuration words through the fuse decoder
module tb_config_fuse_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and live status inputs
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [15:0] CFG_DATA = 16'h0;
   logic XTAL_OR_HS_MODE = 1'b0;
   logic SLEEP_ACTIVE = 1'b0;
   logic SOFT_WATCHDOG_ENABLE = 1'b0;
   logic PLL_LOCKED = 1'b0;
   logic PLL_SWITCH_REQ = 1'b0;
   logic REMAP_REQ = 1'b0;
   // decoded outputs
   logic [2:0] CFG_ADDR;
   logic CFG_LOADED, SECOND_OSCILLATOR_PIN_CLOCK_OUT, REMAP_ALLOWED, CLOCK_SWITCH_EN;
   logic FAILSAFE_MON_EN, PLL_SWITCH_GO, WDT_RUN, WDT_SOFT_BIT_LIVE;
   logic WDT_WINDOW_MODE, BOR_EN, DEBUG_RESERVED;
   logic [15:0] WDT_POST_RATIO;
   logic [7:0] WDT_PRE_RATIO;
   logic [2:0] WDT_WINDOW_EIGHTHS, DEBUG_PAIR;
   logic [31:0] DMT_INTERVAL, DMT_COUNT;
   // configuration memory model and the words loaded this round
   logic [15:0] mem [0:6];
   logic [15:0] w [0:6];
   logic [2:0] prev_addr;
   logic [15:0] lfsr = 16'h6bbd;
   int err_count = 0;
   int total_checks = 0;

   config_fuse_decoder config_fuse_decoder_i (.CORE_CLK(CORE_CLK),
      .RST_N(RST_N), .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA),
      .XTAL_OR_HS_MODE(XTAL_OR_HS_MODE), .SLEEP_ACTIVE(SLEEP_ACTIVE),
      .SOFT_WATCHDOG_ENABLE(SOFT_WATCHDOG_ENABLE), .PLL_LOCKED(PLL_LOCKED),
      .PLL_SWITCH_REQ(PLL_SWITCH_REQ), .REMAP_REQ(REMAP_REQ),
      .CFG_LOADED(CFG_LOADED), .SECOND_OSCILLATOR_PIN_CLOCK_OUT(SECOND_OSCILLATOR_PIN_CLOCK_OUT),
      .REMAP_ALLOWED(REMAP_ALLOWED), .CLOCK_SWITCH_EN(CLOCK_SWITCH_EN),
      .FAILSAFE_MON_EN(FAILSAFE_MON_EN), .PLL_SWITCH_GO(PLL_SWITCH_GO),
      .WDT_POST_RATIO(WDT_POST_RATIO), .WDT_PRE_RATIO(WDT_PRE_RATIO),
      .WDT_RUN(WDT_RUN), .WDT_SOFT_BIT_LIVE(WDT_SOFT_BIT_LIVE),
      .WDT_WINDOW_MODE(WDT_WINDOW_MODE),
      .WDT_WINDOW_EIGHTHS(WDT_WINDOW_EIGHTHS), .BOR_EN(BOR_EN),
      .DEBUG_PAIR(DEBUG_PAIR), .DEBUG_RESERVED(DEBUG_RESERVED),
      .DMT_INTERVAL(DMT_INTERVAL), .DMT_COUNT(DMT_COUNT));

   // 25 MHz clock
   always #20 CORE_CLK = ~CORE_CLK;

   // memory answers one cycle after the address, as the read port expects
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) prev_addr <= 3'h0;
      else prev_addr <= CFG_ADDR;
   end
   // data changes on the falling edge, well away from the sampling edge
   always @(negedge CORE_CLK) begin
      CFG_DATA <= mem[prev_addr];
   end

   // sixteen-bit lfsr, the only source of random values
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // watchdog run state expected for each enable mode
   function automatic logic run_exp(logic [1:0] m, logic slp, logic sft);
      case (m)
         2'h3: return 1'b1;
         2'h2: return sft;
         2'h1: return ~slp;
         default: return 1'b0;
      endcase
   endfunction

   // window size in eighths for each window code
   function automatic logic [2:0] win_exp(logic [1:0] c);
      case (c)
         2'h3: return fuse_pkg::WIN_25;
         2'h2: return fuse_pkg::WIN_375;
         2'h1: return fuse_pkg::WIN_50;
         default: return fuse_pkg::WIN_75;
      endcase
   endfunction

   // single-bit comparison
   task automatic chk_bit(string name, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // multi-bit comparison
   task automatic chk_val(string name, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // closing report, the one place the run ends
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // set when a load never finishes; the main loop then reports
   logic hung = 1'b0;

   // fill memory, reset for two cycles and wait for the load to finish
   task automatic load_cfg(int i);
      int n;
      for (int k = 0; k < 7; k++) mem[k] = rnd();
      // first four rounds walk every code of the two-bit fields
      if (i < 4) begin
         mem[0][8:7] = 2'(i);
         mem[1][6:5] = 2'(i);
         mem[1][9:8] = 2'(i);
         mem[3][1:0] = 2'(i);
         mem[1][3:0] = 4'(15 - i);
      end
      for (int k = 0; k < 7; k++) w[k] = mem[k];
      RST_N = 1'b0;
      repeat (2) @(negedge CORE_CLK);
      chk_val("reset addr", 32'h0, 32'(CFG_ADDR));
      chk_val("reset post", 32'h1, 32'(WDT_POST_RATIO));
      chk_val("reset pre", 32'h20, 32'(WDT_PRE_RATIO));
      chk_val("reset win", 32'h6, 32'(WDT_WINDOW_EIGHTHS));
      chk_bit("reset loaded", 1'b0, CFG_LOADED);
      chk_bit("reset run", 1'b0, WDT_RUN);
      RST_N = 1'b1;
      n = 0;
      while (!CFG_LOADED && n < 20) begin
         @(negedge CORE_CLK);
         n++;
      end
      // a load that never finishes ends the run as a failure
      if (!CFG_LOADED) begin
         err_count++;
         hung = 1'b1;
      end
      chk_val("load edges", 32'h9, 32'(n));
   endtask

   // random live inputs against the loaded words, one edge of latency
   task automatic live_check();
      logic [15:0] r;
      logic [31:0] e;
      logic b;
      logic go;
      repeat (6) begin
         r = rnd();
         XTAL_OR_HS_MODE = r[0];
         SLEEP_ACTIVE = r[1];
         SOFT_WATCHDOG_ENABLE = r[2];
         PLL_LOCKED = r[3];
         PLL_SWITCH_REQ = r[4];
         @(negedge CORE_CLK);
         chk_bit("second_oscillator_pin out", w[0][5] & ~r[0], SECOND_OSCILLATOR_PIN_CLOCK_OUT);
         chk_bit("switch en", ~w[0][8], CLOCK_SWITCH_EN);
         chk_bit("monitor", w[0][8:7] == 2'h0, FAILSAFE_MON_EN);
         // no pll switch while the policy forbids switching at all
         go = r[4] & ~w[0][8] & (~w[0][9] | r[3]);
         chk_bit("pll go", go, PLL_SWITCH_GO);
         e = 32'h1 << w[1][3:0];
         chk_val("post", e, 32'(WDT_POST_RATIO));
         e = w[1][4] ? 32'h80 : 32'h20;
         chk_val("pre", e, 32'(WDT_PRE_RATIO));
         b = run_exp(w[1][6:5], r[1], r[2]);
         chk_bit("wdt run", b, WDT_RUN);
         b = (w[1][6:5] == 2'h2);
         chk_bit("soft live", b, WDT_SOFT_BIT_LIVE);
         chk_bit("win mode", ~w[1][7], WDT_WINDOW_MODE);
         if (!w[1][7]) begin
            e = 32'(win_exp(w[1][9:8]));
            chk_val("win", e, 32'(WDT_WINDOW_EIGHTHS));
         end
         chk_bit("bor", w[2][3], BOR_EN);
         e = (32'h8 >> w[3][1:0]) & 32'h7;
         chk_val("pair", e, 32'(DEBUG_PAIR));
         b = (w[3][1:0] == 2'h0);
         chk_bit("dbg rsvd", b, DEBUG_RESERVED);
         chk_val("interval", {w[5], w[4]}, DMT_INTERVAL);
         chk_val("count", {16'h0, w[6]}, DMT_COUNT);
      end
   endtask

   // memory changing after the load must not reach the outputs
   task automatic hold_check();
      for (int k = 0; k < 7; k++) mem[k] = ~w[k];
      repeat (3) @(negedge CORE_CLK);
      chk_val("held ivl", {w[5], w[4]}, DMT_INTERVAL);
      chk_val("held cnt", {16'h0, w[6]}, DMT_COUNT);
      chk_bit("held bor", w[2][3], BOR_EN);
   endtask

   // one remap, then a lock bit of one forbids any further remap
   task automatic remap_check();
      chk_bit("remap first", 1'b1, REMAP_ALLOWED);
      REMAP_REQ = 1'b1;
      @(negedge CORE_CLK);
      REMAP_REQ = 1'b0;
      repeat (2) @(negedge CORE_CLK);
      chk_bit("remap again", ~w[0][6], REMAP_ALLOWED);
   endtask

   // main sequence; a hung load skips straight to the report
   initial begin
      for (int i = 0; i < 16; i++) begin
         load_cfg(i);
         if (hung) break;
         live_check();
         hold_check();
         remap_check();
      end
      wrap_up();
   end
endmodule
